// file: hw/rss_pkg.sv
package rss_pkg;
  // Strap pin vector bit positions
  localparam int STRAP_W = 14;
  localparam int B_ADDR0 = 0;
  localparam int B_IDE_BUF = 1;
  localparam int B_BUS_CYC = 2;
  localparam int B_FB_DLY = 3;
  localparam int B_CPU_DLY = 4;
  localparam int B_MEM_DIR = 5;
  localparam int B_CS0 = 6;
  localparam int B_CS1 = 7;
  localparam int B_CS2 = 8;
  localparam int B_CS3 = 9;
  localparam int B_ADDR1 = 10;
  localparam int B_BHE = 11;
  localparam int B_NMI = 12;
  localparam int B_INTR = 13;
  // Pull direction during reset, 1 = pull-up
  localparam logic [13:0] PULL_UP = 14'h3013;
  // Captured value before any sample: the unstrapped defaults
  localparam logic [13:0] STRAP_RST = 14'h3013;
  // Synchroniser depth for the reset pin
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic l2_cache_en;
    logic ide_buf_active_high;
    logic osc_1x;
    logic fb_clock_delay;
    logic cpu_clock_delay;
    logic legacy_mem;
    logic clock_stop_en;
    logic cpu_clock_2x;
    logic cpu_486;
    logic resume_on_event2;
    logic ready_on_alt_pin;
    logic cpu_5v;
    logic isa_3v3;
    logic cpu_1x_readback;
  } rss_opts_s;
endpackage

// file: hw/rss_sync.sv
`timescale 1ns/1ps
module rss_sync #(
  parameter int STAGES = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  output logic level_out,
  output logic rise_out
);
  typedef struct packed {
    logic [STAGES-1:0] sh;
    logic lvl;
    logic rise;
  } rss_sync_s;
  rss_sync_s s_q, s_d;
  // Agreement test reads the last two stages
  if (STAGES < 3) begin : g_bad_stages
    $error("rss_sync needs at least three stages");
  end
  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[STAGES-2:0], d_in};
    s_d.rise = 1'b0;
    // Change counts once last two stages agree
    if (s_q.sh[STAGES-1] == s_q.sh[STAGES-2] && s_q.sh[STAGES-1] != s_q.lvl) begin
      s_d.lvl = s_q.sh[STAGES-1];
      s_d.rise = s_q.sh[STAGES-1];
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign level_out = s_q.lvl;
  assign rise_out = s_q.rise;
endmodule

// file: hw/rss_top.sv
`timescale 1ns/1ps
// Functional notes
// - Capture straps at primary reset rising edge
// - Weak pulls enabled only during reset
// - Low address strap low enables cache
// - IDE buffer enable polarity from strap
// - Bus cycle strap high means 1X oscillator
// - Feedback clock strap high adds delay
// - CPU clock strap low adds delay
// - Memory direction strap high selects legacy
// - Both low cache selects high enable clockstop
// - Third cache select high gives 2X
// - Fourth cache select high gives 486
// - Second address strap routes resume reset
// - Byte-high strap picks ready pin assignment
// - NMI strap low means 5V CPU
// - INTR strap low means 3.3V ISA
// - Strap pins are inputs during reset
// - CPU 1X/2X strap readable, read-only
module rss_top (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic PRIMARY_RESET_N_IN,
  // Strap pins, input side of each pad
  input wire logic [13:0] STRAP_PIN_IN,
  // Functional values from the core for pads after reset
  input wire logic [13:0] CORE_PIN_DATA_IN,
  input wire logic [13:0] CORE_PIN_OE_IN,
  input wire logic IDE_BUFFER_ENABLE_IN,
  input wire logic RESUME_RESET_IN,
  // Strap pad control
  output logic [13:0] STRAP_PIN_OUT,
  output logic [13:0] STRAP_PIN_OE_OUT,
  output logic [13:0] PULL_EN_OUT,
  output logic [13:0] PULL_UP_OUT,
  // Reset and derived pins
  output logic SECONDARY_RESET_N_OUT,
  output logic IDE_DATA_BUFFER_ENABLE_OUT,
  output logic EXT_POWER_EVENT2_OUT,
  output logic EXT_POWER_EVENT2_OE_OUT,
  // Captured options
  output rss_pkg::rss_opts_s OPTS_OUT,
  output logic OPTS_VALID_OUT
);
  // Pin stages and the settled strap level live with the rest of the state
  typedef struct packed {
    logic valid;
    logic [13:0] strap_s1;
    logic [13:0] strap_s2;
    logic [13:0] strap_s3;
    logic [13:0] strap_lvl;
    logic [13:0] pin_o;
    logic [13:0] pin_oe;
    logic [13:0] pull_en;
    logic [13:0] pull_up;
    logic sec_rst_n;
    logic ide_dbe;
    logic ev2_o;
    logic ev2_oe;
    rss_pkg::rss_opts_s opts;
  } rss_state_s;

  rss_state_s s_q, s_d;
  logic prim_lvl;
  logic prim_rise;
  logic [13:0] strap_agree;

  // Refuse package edits that the fixed pin vector cannot carry
  if ($bits(rss_pkg::rss_opts_s) != rss_pkg::STRAP_W) begin : g_bad_opts
    $error("option struct must match the strap width");
  end
  if (rss_pkg::B_INTR >= rss_pkg::STRAP_W) begin : g_bad_pos
    $error("strap bit position outside the pin vector");
  end
  if (rss_pkg::SYNC_STAGES < 3) begin : g_bad_sync
    $error("primary reset needs three synchroniser stages");
  end

  // Primary reset pin arrives from outside the clock domain
  rss_sync #(
    .STAGES(rss_pkg::SYNC_STAGES)
  ) u_prim_sync (
    .clk_in(MCLK_IN),
    .rst_n_in(RESETN_IN),
    .d_in(PRIMARY_RESET_N_IN),
    .level_out(prim_lvl),
    .rise_out(prim_rise)
  );

  function automatic rss_pkg::rss_opts_s decode(input logic [13:0] st);
    rss_pkg::rss_opts_s o;
    o.l2_cache_en = ~st[rss_pkg::B_ADDR0];
    o.ide_buf_active_high = ~st[rss_pkg::B_IDE_BUF];
    o.osc_1x = st[rss_pkg::B_BUS_CYC];
    o.fb_clock_delay = st[rss_pkg::B_FB_DLY];
    o.cpu_clock_delay = ~st[rss_pkg::B_CPU_DLY];
    o.legacy_mem = st[rss_pkg::B_MEM_DIR];
    o.clock_stop_en = st[rss_pkg::B_CS0] & st[rss_pkg::B_CS1];
    o.cpu_clock_2x = st[rss_pkg::B_CS2];
    o.cpu_486 = st[rss_pkg::B_CS3];
    o.resume_on_event2 = st[rss_pkg::B_ADDR1];
    o.ready_on_alt_pin = st[rss_pkg::B_BHE];
    o.cpu_5v = ~st[rss_pkg::B_NMI];
    o.isa_3v3 = ~st[rss_pkg::B_INTR];
    o.cpu_1x_readback = ~st[rss_pkg::B_CS2];
    return o;
  endfunction

  // Unstrapped defaults; pads released and the secondary reset held
  localparam rss_state_s STATE_RST = '{
    valid: 1'b0,
    strap_s1: rss_pkg::STRAP_RST,
    strap_s2: rss_pkg::STRAP_RST,
    strap_s3: rss_pkg::STRAP_RST,
    strap_lvl: rss_pkg::STRAP_RST,
    pin_o: 14'h0000,
    pin_oe: 14'h0000,
    pull_en: 14'h3fff,
    pull_up: rss_pkg::PULL_UP,
    sec_rst_n: 1'b0,
    ide_dbe: 1'b1,
    ev2_o: 1'b0,
    ev2_oe: 1'b0,
    opts: decode(rss_pkg::STRAP_RST)
  };

  always_comb begin
    s_d = s_q;
    // Straps settle long before release, so the extra stage costs nothing
    s_d.strap_s1 = STRAP_PIN_IN;
    s_d.strap_s2 = s_q.strap_s1;
    s_d.strap_s3 = s_q.strap_s2;
    // Per pin, a change counts once stages two and three agree
    strap_agree = ~(s_q.strap_s2 ^ s_q.strap_s3);
    s_d.strap_lvl = (strap_agree & s_q.strap_s3) | (~strap_agree & s_q.strap_lvl);
    // Constant, registered so every output leaves a flop
    s_d.pull_up = rss_pkg::PULL_UP;

    // Held low one cycle past capture so gated strap drivers stay on
    // secondary reset held through sampling
    s_d.sec_rst_n = prim_lvl & ~prim_rise & s_q.valid;
    // Options stay readable in reset; only the valid flag drops
    if (!prim_lvl) begin
      s_d.valid = 1'b0;
    end
    if (prim_rise) begin
      s_d.opts = decode(s_q.strap_lvl);
      s_d.valid = 1'b1;
    end

    if (s_d.valid && s_d.sec_rst_n) begin
      s_d.pin_o = CORE_PIN_DATA_IN;
      s_d.pin_oe = CORE_PIN_OE_IN;
    end else begin
      s_d.pin_o = '0;
      s_d.pin_oe = '0;
    end
    // Pulls drop with valid, a cycle before the secondary reset
    // pulls only in reset
    if (s_d.valid) begin
      s_d.pull_en = 14'h0000;
    end else begin
      s_d.pull_en = 14'h3fff;
    end

    if (s_q.opts.ide_buf_active_high) begin
      s_d.ide_dbe = IDE_BUFFER_ENABLE_IN;
    end else begin
      s_d.ide_dbe = ~IDE_BUFFER_ENABLE_IN;
    end
    // Pad stays an input until the options are known
    // resume reset on event pin
    if (s_q.valid && s_q.opts.resume_on_event2) begin
      s_d.ev2_oe = 1'b1;
      s_d.ev2_o = RESUME_RESET_IN;
    end else begin
      s_d.ev2_oe = 1'b0;
      s_d.ev2_o = 1'b0;
    end
  end

  // options change only on a sampling edge or when RESETN_IN loads the unstrapped defaults
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign STRAP_PIN_OUT = s_q.pin_o;
  assign STRAP_PIN_OE_OUT = s_q.pin_oe;
  assign PULL_EN_OUT = s_q.pull_en;
  assign PULL_UP_OUT = s_q.pull_up;
  assign SECONDARY_RESET_N_OUT = s_q.sec_rst_n;
  assign IDE_DATA_BUFFER_ENABLE_OUT = s_q.ide_dbe;
  assign EXT_POWER_EVENT2_OUT = s_q.ev2_o;
  assign EXT_POWER_EVENT2_OE_OUT = s_q.ev2_oe;
  assign OPTS_OUT = s_q.opts;
  assign OPTS_VALID_OUT = s_q.valid;
endmodule

// file: verification/rss_asserts.sv
`timescale 1ns/1ps
module rss_asserts (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESETN_IN,
  input wire logic PRIMARY_RESET_N_IN,
  // Core side
  input wire logic IDE_BUFFER_ENABLE_IN,
  // Outputs watched
  input wire logic [13:0] STRAP_PIN_OE_OUT,
  input wire logic [13:0] PULL_EN_OUT,
  input wire logic SECONDARY_RESET_N_OUT,
  input wire logic IDE_DATA_BUFFER_ENABLE_OUT,
  input wire logic EXT_POWER_EVENT2_OE_OUT,
  input wire rss_pkg::rss_opts_s OPTS_OUT,
  input wire logic OPTS_VALID_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  pulls_on_a:
    assert property (!OPTS_VALID_OUT |-> PULL_EN_OUT == 14'h3fff) else $error("pulls off too early");
  pulls_off_a:
    assert property (OPTS_VALID_OUT |-> PULL_EN_OUT == 14'h0000) else $error("pulls left on");
  capture_time_a:
    assert property ($rose(PRIMARY_RESET_N_IN) |-> ##[2:7] $rose(OPTS_VALID_OUT)) else $error("late capture");
  sec_low_a:
    assert property (!OPTS_VALID_OUT |-> !SECONDARY_RESET_N_OUT) else $error("early reset release");
  pad_input_a:
    assert property (!SECONDARY_RESET_N_OUT |-> STRAP_PIN_OE_OUT == 14'h0000) else $error("pad driven in reset");
  opts_hold_a:
    assert property (OPTS_VALID_OUT && $past(OPTS_VALID_OUT) |-> $stable(OPTS_OUT)) else $error("options moved");
  readback_a:
    assert property (OPTS_OUT.cpu_1x_readback == !OPTS_OUT.cpu_clock_2x) else $error("readback wrong");
  dbe_polarity_a:
    assert property (SECONDARY_RESET_N_OUT && $past(SECONDARY_RESET_N_OUT) |-> IDE_DATA_BUFFER_ENABLE_OUT
      == ($past(IDE_BUFFER_ENABLE_IN) ^ !OPTS_OUT.ide_buf_active_high)) else $error("buffer polarity");
  event2_oe_a:
    assert property (OPTS_VALID_OUT && $past(OPTS_VALID_OUT) |->
      EXT_POWER_EVENT2_OE_OUT == OPTS_OUT.resume_on_event2) else $error("event2 drive wrong");
endmodule
bind rss_top rss_asserts u_chk (.MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .PRIMARY_RESET_N_IN(PRIMARY_RESET_N_IN),
  .IDE_BUFFER_ENABLE_IN(IDE_BUFFER_ENABLE_IN), .STRAP_PIN_OE_OUT(STRAP_PIN_OE_OUT), .PULL_EN_OUT(PULL_EN_OUT),
  .SECONDARY_RESET_N_OUT(SECONDARY_RESET_N_OUT), .IDE_DATA_BUFFER_ENABLE_OUT(IDE_DATA_BUFFER_ENABLE_OUT),
  .EXT_POWER_EVENT2_OE_OUT(EXT_POWER_EVENT2_OE_OUT), .OPTS_OUT(OPTS_OUT), .OPTS_VALID_OUT(OPTS_VALID_OUT));

// file: verification/rss_board.sv
`timescale 1ns/1ps
module rss_board (
  // Board setup
  input wire logic clk_in,
  input wire logic [13:0] strap_in,
  input wire logic [13:0] fitted_in,
  input wire logic use_drv_in,
  // Device pads
  input wire logic [13:0] pad_out_in,
  input wire logic [13:0] pad_oe_in,
  input wire logic [13:0] pull_en_in,
  input wire logic [13:0] pull_up_in,
  input wire logic sec_rst_n_in,
  output logic [13:0] pin_out
);
  logic tog = 1'b0;
  logic [13:0] drv;
  logic [13:0] idle;
  always @(posedge clk_in) tog <= ~tog;
  assign drv = fitted_in & {14{!use_drv_in || !sec_rst_n_in}};
  // Undriven pad without pulls wanders, so stale values never pass
  assign idle = (pull_en_in & pull_up_in) | (~pull_en_in & {14{tog}});
  assign pin_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ((drv & strap_in) | (~drv & idle)));
endmodule

// file: verification/test_reset_strap_sampler.sv
`timescale 1ns/1ps
module test_reset_strap_sampler;
  logic clk = 1'b0, rst_n = 1'b0, prim_n = 1'b0, ide_en = 1'b0, rsm = 1'b0, use_drv = 1'b0, sec_n, valid;
  logic [13:0] strap = '0, fitted = '0, core_d = '0, core_oe = '0, pin, pad_out, pad_oe, pull_en, pull_up;
  logic dbe, ev2, ev2_oe;
  logic [13:0] eff;
  rss_pkg::rss_opts_s opts, held;
  int failures = 0, total_checks = 0, seed = 32'h1ec3c54a;
  initial forever #50 clk = ~clk;
  rss_top u_dut (.MCLK_IN(clk), .RESETN_IN(rst_n), .PRIMARY_RESET_N_IN(prim_n), .STRAP_PIN_IN(pin),
    .CORE_PIN_DATA_IN(core_d), .CORE_PIN_OE_IN(core_oe), .IDE_BUFFER_ENABLE_IN(ide_en), .RESUME_RESET_IN(rsm),
    .STRAP_PIN_OUT(pad_out), .STRAP_PIN_OE_OUT(pad_oe), .PULL_EN_OUT(pull_en), .PULL_UP_OUT(pull_up),
    .SECONDARY_RESET_N_OUT(sec_n), .IDE_DATA_BUFFER_ENABLE_OUT(dbe), .EXT_POWER_EVENT2_OUT(ev2),
    .EXT_POWER_EVENT2_OE_OUT(ev2_oe), .OPTS_OUT(opts), .OPTS_VALID_OUT(valid));
  rss_board u_board (.clk_in(clk), .strap_in(strap), .fitted_in(fitted), .use_drv_in(use_drv),
    .pad_out_in(pad_out), .pad_oe_in(pad_oe), .pull_en_in(pull_en), .pull_up_in(pull_up),
    .sec_rst_n_in(sec_n), .pin_out(pin));
  function automatic rss_pkg::rss_opts_s exp_f(input logic [13:0] s);
    exp_f = {~s[0], ~s[1], s[2], s[3], ~s[4], s[5], s[6] & s[7], s[8], s[9], s[10], s[11], ~s[12], ~s[13], ~s[8]};
  endfunction
  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk) prim_n = 1'b0;
      use_drv = i[0];
      fitted = i == 0 ? 14'h0 : (i == 1 ? 14'h3fff : 14'($random(seed)));
      strap = i == 1 ? 14'h2fec : 14'($random(seed));
      if (fitted[12] && fitted[13] && !strap[12] && !strap[13]) strap[13] = 1'b1;
      repeat (6) @(negedge clk);
      check("pull_en", pull_en, 14'h3fff);
      check("pad_oe", pad_oe, 14'h0);
      check("valid_lo", {13'h0, valid}, 14'h0);
      check("pull_up", pull_up, rss_pkg::PULL_UP);
      prim_n = 1'b1;
      for (int n = 0; n < 20 && !sec_n; n++) @(negedge clk);
      held = opts;
      eff = (fitted & strap) | (~fitted & rss_pkg::PULL_UP);
      check("opts", opts, exp_f(eff));
      check("sec_n", {13'h0, sec_n}, 14'h1);
      check("valid_hi", {13'h0, valid}, 14'h1);
      strap = ~strap;
      repeat (5) begin
        @(negedge clk);
        check("dbe", {13'h0, dbe}, {13'h0, ide_en ^ eff[1]});
        check("ev2", {12'h0, ev2_oe, ev2}, {12'h0, eff[10], eff[10] & rsm});
        check("pad_oe_run", pad_oe, core_oe);
        check("pad_out_run", pad_out, core_d);
        ide_en = 1'($random(seed));
        rsm = 1'($random(seed));
        core_oe = 14'($random(seed));
        core_d = 14'($random(seed));
      end
      check("held", opts, held);
      check("pull_off", pull_en, 14'h0);
    end
    results();
  end
  initial begin
    #200us;
    failures++;
    results();
  end
endmodule
